// ==== logic/compact_timer_pkg.sv ====
// Constants, register map and field layout of the compact 10-bit compare timer.
// Assumes a byte-wide register port and a single system clock.
// ----------------------------------------------------------------------------
// How it works
// - Enable rising edge restores initial output level
// - Period code compared with counter bits 9-7
// - Period code zero lets counter overflow
// - Mode field: compare, PWM, timer; 01 undefined
// - Compare A match applies output function
// - PWM: force inactive, force active, waveform
// - Output control bit: initial or active level
// - Polarity bit inverts pin in all modes, timer included
// - Swap bit exchanges period and duty sources
// - Clear select: A match or period match
// - Counter readable only, split low/high bytes
// - Compare A value readable and writable, split
// - Compare mode, clear select 0: both flags
// - Clear select 1 sets no period flag outside PWM mode
// - Compare A zero: overflow at 3FF, no flag
// - Of the two matches, only compare A changes the pin
// - Same level requested gives no visible change
// - Timer mode: pin not driven, counting continues
// - Enable rise clears counter; fall holds count
// - Pause bit freezes and resumes the counter
// - Clock select picks internal or external source
// - Low bytes pass an 8-bit holding buffer
// ----------------------------------------------------------------------------
package compact_timer_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 10;
  localparam logic [2:0] OFF_CONTROL_0 = 3'h0;
  localparam logic [2:0] OFF_CONTROL_1 = 3'h1;
  localparam logic [2:0] OFF_COUNT_LOW = 3'h2;
  localparam logic [2:0] OFF_COUNT_HIGH = 3'h3;
  localparam logic [2:0] OFF_COMPARE_LOW = 3'h4;
  localparam logic [2:0] OFF_COMPARE_HIGH = 3'h5;
  localparam logic [2:0] OFF_MATCH_STATUS = 3'h6;
  localparam logic [7:0] CONTROL_0_RESET = 8'h00;
  localparam logic [7:0] CONTROL_1_RESET = 8'h00;
  localparam logic [9:0] COMPARE_RESET = 10'h000;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int unsigned C0_PAUSE = 7;
  localparam int unsigned C0_CLOCK_HI = 6;
  localparam int unsigned C0_CLOCK_LO = 4;
  localparam int unsigned C0_ENABLE = 3;
  localparam int unsigned C0_PERIOD_HI = 2;
  localparam int unsigned C0_PERIOD_LO = 0;
  localparam int unsigned C1_MODE_HI = 7;
  localparam int unsigned C1_MODE_LO = 6;
  localparam int unsigned C1_FUNC_HI = 5;
  localparam int unsigned C1_FUNC_LO = 4;
  localparam int unsigned C1_OUT_CONTROL = 3;
  localparam int unsigned C1_POLARITY = 2;
  localparam int unsigned C1_SWAP = 1;
  localparam int unsigned C1_CLEAR_SELECT = 0;
  localparam int unsigned STAT_COMPARE_A = 0;
  localparam int unsigned STAT_PERIOD = 1;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned PRESCALE_W = 6;
  localparam logic [5:0] DIV_SYS_4_MASK = 6'h03;
  localparam logic [5:0] DIV_H_16_MASK = 6'h0f;
  localparam logic [5:0] DIV_H_64_MASK = 6'h3f;
  localparam logic [10:0] OVERFLOW_PERIOD = 11'h400;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_UNDEFINED = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } mode_t;

  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'h0,
    CLK_SYS = 3'h1,
    CLK_H_DIV16 = 3'h2,
    CLK_H_DIV64 = 3'h3,
    CLK_SUB_A = 3'h4,
    CLK_SUB_B = 3'h5,
    CLK_EXT_RISE = 3'h6,
    CLK_EXT_FALL = 3'h7
  } clock_select_t;

endpackage

// ==== logic/compact_timer_module.sv ====
// Compact 10-bit timer with compare A and period comparators, PWM output.
// Assumes a byte register port on i_clock; the fast internal clock is i_clock
// and the sub clock and external count input arrive asynchronously.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module compact_timer_module (
  input wire logic i_clock, // System clock, 100 MHz
  input wire logic i_arst_n, // Asynchronous reset, active low
  input wire logic [2:0] i_address, // Register address
  input wire logic [7:0] i_write_data, // Register write data
  input wire logic i_write, // Write strobe
  input wire logic i_read, // Read strobe
  output logic [7:0] o_read_data, // Read data, one cycle after strobe
  input wire logic i_sub_clock, // Low speed sub clock, asynchronous
  input wire logic i_external_count_input, // External count pin, asynchronous
  output logic o_timer_output_pin, // Timer output
  output logic o_timer_output_pin_inverse, // Inverse of timer output
  output logic o_timer_output_enable, // High while the pin is driven
  output logic o_compare_a_match_flag, // One-cycle compare A event
  output logic o_period_match_flag // One-cycle period event
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] control_0_q, control_1_q;
  logic [9:0] count_q, count_d;
  logic [9:0] compare_a_value_q;
  logic [7:0] low_buffer_q, low_buffer_d;
  logic [7:0] read_data_d;
  logic [1:0] status_q, status_d;
  logic enable_prev_q;
  logic cmp_level_q, cmp_level_d;
  logic pin_q, pin_d;
  logic oe_q;
  logic a_pulse_q, p_pulse_q;
  logic [5:0] prescale_q;
  logic [2:0] ext_sync_q;
  logic [2:0] sub_sync_q;

  // --------------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------------
  wire count_pause_bit = control_0_q[compact_timer_pkg::C0_PAUSE];
  wire [2:0] count_clock_select =
    control_0_q[compact_timer_pkg::C0_CLOCK_HI:compact_timer_pkg::C0_CLOCK_LO];
  wire counter_enable_bit = control_0_q[compact_timer_pkg::C0_ENABLE];
  wire [2:0] period_code =
    control_0_q[compact_timer_pkg::C0_PERIOD_HI:compact_timer_pkg::C0_PERIOD_LO];
  wire [1:0] operating_mode_field =
    control_1_q[compact_timer_pkg::C1_MODE_HI:compact_timer_pkg::C1_MODE_LO];
  wire [1:0] output_function_field =
    control_1_q[compact_timer_pkg::C1_FUNC_HI:compact_timer_pkg::C1_FUNC_LO];
  wire output_control_bit = control_1_q[compact_timer_pkg::C1_OUT_CONTROL];
  wire polarity_bit = control_1_q[compact_timer_pkg::C1_POLARITY];
  wire period_duty_swap_bit = control_1_q[compact_timer_pkg::C1_SWAP];
  wire clear_select_bit = control_1_q[compact_timer_pkg::C1_CLEAR_SELECT];

  wire is_pwm = operating_mode_field == compact_timer_pkg::MODE_PWM;
  wire is_timer = operating_mode_field == compact_timer_pkg::MODE_TIMER;
  wire enable_rise = counter_enable_bit && !enable_prev_q;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire wr_c0 = i_write && i_address == compact_timer_pkg::OFF_CONTROL_0;
  wire wr_c1 = i_write && i_address == compact_timer_pkg::OFF_CONTROL_1;
  wire wr_cmp_lo = i_write && i_address == compact_timer_pkg::OFF_COMPARE_LOW;
  wire wr_cmp_hi = i_write && i_address == compact_timer_pkg::OFF_COMPARE_HIGH;
  wire wr_stat = i_write && i_address == compact_timer_pkg::OFF_MATCH_STATUS;
  wire rd_cnt_hi = i_read && i_address == compact_timer_pkg::OFF_COUNT_HIGH;
  wire rd_cmp_hi = i_read && i_address == compact_timer_pkg::OFF_COMPARE_HIGH;

  // --------------------------------------------------------------------------
  // Counting clock selection
  // --------------------------------------------------------------------------
  // Slow sources become one-cycle ticks; the counter never leaves i_clock.
  wire ext_rise = ext_sync_q[1] && !ext_sync_q[2];
  wire ext_fall = !ext_sync_q[1] && ext_sync_q[2];
  wire sub_rise = sub_sync_q[1] && !sub_sync_q[2];
  wire tick_sys4 = (prescale_q & compact_timer_pkg::DIV_SYS_4_MASK) ==
    compact_timer_pkg::DIV_SYS_4_MASK;
  wire tick_h16 = (prescale_q & compact_timer_pkg::DIV_H_16_MASK) ==
    compact_timer_pkg::DIV_H_16_MASK;
  wire tick_h64 = prescale_q == compact_timer_pkg::DIV_H_64_MASK;
  logic source_tick;

  always_comb begin
    case (count_clock_select)
      compact_timer_pkg::CLK_SYS_DIV4: source_tick = tick_sys4;
      compact_timer_pkg::CLK_SYS: source_tick = 1'b1;
      compact_timer_pkg::CLK_H_DIV16: source_tick = tick_h16;
      compact_timer_pkg::CLK_H_DIV64: source_tick = tick_h64;
      compact_timer_pkg::CLK_SUB_A, compact_timer_pkg::CLK_SUB_B: source_tick = sub_rise;
      compact_timer_pkg::CLK_EXT_RISE: source_tick = ext_rise;
      compact_timer_pkg::CLK_EXT_FALL: source_tick = ext_fall;
      default: source_tick = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Comparators
  // --------------------------------------------------------------------------
  wire count_tick = counter_enable_bit && !count_pause_bit && !enable_rise;
  wire count_step = count_tick && source_tick;
  wire [10:0] count_inc = {1'b0, count_q} + 11'h001;
  wire overflow = count_inc[10];
  // Compare A of zero never matches: the count reaches zero only by wrapping
  wire a_hit = count_step && compare_a_value_q != 10'h000 &&
    count_inc[9:0] == compare_a_value_q;
  wire p_code_hit = count_inc[9:7] == period_code && count_inc[6:0] == 7'h00;
  wire p_hit = count_step && (period_code == 3'h0 ? overflow : p_code_hit);
  wire clear_on_a = is_pwm ? period_duty_swap_bit : clear_select_bit;
  wire clear_hit = clear_on_a ? a_hit : p_hit;
  wire a_set = a_hit;
  wire p_set = p_hit && (is_pwm || !clear_select_bit);

  always_comb begin
    count_d = count_q;
    if (enable_rise) begin
      count_d = 10'h000;
    end else if (count_step) begin
      count_d = (clear_hit || overflow) ? 10'h000 : count_inc[9:0];
    end
  end

  // --------------------------------------------------------------------------
  // Output level
  // --------------------------------------------------------------------------
  always_comb begin
    cmp_level_d = cmp_level_q;
    if (enable_rise) begin
      cmp_level_d = output_control_bit;
    end else if (a_hit && !is_pwm) begin
      case (output_function_field)
        2'h0: cmp_level_d = cmp_level_q;
        2'h1: cmp_level_d = 1'b0;
        2'h2: cmp_level_d = 1'b1;
        2'h3: cmp_level_d = !cmp_level_q;
        default: cmp_level_d = cmp_level_q;
      endcase
    end
  end

  // Duty at or above the period keeps the count below it: 100 percent duty
  wire [10:0] period_code_span = (period_code == 3'h0) ?
    compact_timer_pkg::OVERFLOW_PERIOD : {1'b0, period_code, 7'h00};
  wire [10:0] duty_value = period_duty_swap_bit ?
    period_code_span : {1'b0, compare_a_value_q};
  wire pwm_active = {1'b0, count_q} < duty_value;
  logic pwm_level;

  always_comb begin
    case (output_function_field)
      2'h0: pwm_level = !output_control_bit;
      2'h1: pwm_level = output_control_bit;
      2'h2: pwm_level = pwm_active ? output_control_bit : !output_control_bit;
      default: pwm_level = !output_control_bit;
    endcase
  end

  wire pin_raw = is_pwm ? pwm_level : cmp_level_q;
  assign pin_d = pin_raw ^ polarity_bit;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  // A flag set in the same cycle as its write-one clear survives
  assign status_d = (status_q & ~(wr_stat ? i_write_data[1:0] : 2'h0)) | {p_set, a_set};

  always_comb begin
    low_buffer_d = low_buffer_q;
    if (wr_cmp_lo) begin
      low_buffer_d = i_write_data;
    end else if (rd_cnt_hi) begin
      low_buffer_d = count_q[7:0];
    end else if (rd_cmp_hi) begin
      low_buffer_d = compare_a_value_q[7:0];
    end
  end

  always_comb begin
    case (i_address)
      compact_timer_pkg::OFF_CONTROL_0: read_data_d = control_0_q;
      compact_timer_pkg::OFF_CONTROL_1: read_data_d = control_1_q;
      compact_timer_pkg::OFF_COUNT_LOW: read_data_d = low_buffer_q;
      compact_timer_pkg::OFF_COUNT_HIGH: read_data_d = {6'h00, count_q[9:8]};
      compact_timer_pkg::OFF_COMPARE_LOW: read_data_d = low_buffer_q;
      compact_timer_pkg::OFF_COMPARE_HIGH: read_data_d = {6'h00, compare_a_value_q[9:8]};
      compact_timer_pkg::OFF_MATCH_STATUS: read_data_d = {6'h00, status_q};
      default: read_data_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_0_q <= compact_timer_pkg::CONTROL_0_RESET;
      control_1_q <= compact_timer_pkg::CONTROL_1_RESET;
      compare_a_value_q <= compact_timer_pkg::COMPARE_RESET;
      low_buffer_q <= 8'h00;
      status_q <= 2'h0;
      o_read_data <= 8'h00;
    end else begin
      if (wr_c0) control_0_q <= i_write_data;
      if (wr_c1) control_1_q <= i_write_data;
      if (wr_cmp_hi) compare_a_value_q <= {i_write_data[1:0], low_buffer_q};
      low_buffer_q <= low_buffer_d;
      status_q <= status_d;
      o_read_data <= i_read ? read_data_d : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Counter, synchronisers and pin
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_q <= 10'h000;
      enable_prev_q <= 1'b0;
      prescale_q <= 6'h00;
      ext_sync_q <= 3'h0;
      sub_sync_q <= 3'h0;
    end else begin
      count_q <= count_d;
      enable_prev_q <= counter_enable_bit;
      prescale_q <= prescale_q + 6'h01;
      ext_sync_q <= {ext_sync_q[1:0], i_external_count_input};
      sub_sync_q <= {sub_sync_q[1:0], i_sub_clock};
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmp_level_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      a_pulse_q <= 1'b0;
      p_pulse_q <= 1'b0;
    end else begin
      cmp_level_q <= cmp_level_d;
      pin_q <= pin_d;
      oe_q <= !is_timer;
      a_pulse_q <= a_set;
      p_pulse_q <= p_set;
    end
  end

  assign o_timer_output_pin = pin_q;
  assign o_timer_output_pin_inverse = !pin_q;
  assign o_timer_output_enable = oe_q;
  assign o_compare_a_match_flag = a_pulse_q;
  assign o_period_match_flag = p_pulse_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  a_enable_rise_clear: assert property (
    enable_rise |=> count_q == 10'h000
  ) else $error("Counter not cleared on enable rise");

  a_pause_freezes_count: assert property (
    counter_enable_bit && count_pause_bit && !enable_rise |=> $stable(count_q)
  ) else $error("Counter moved while paused");

  a_period_one_clear: assert property (
    !is_pwm && !clear_select_bit && period_code == 3'h1 && count_step &&
    count_q == 10'h07f |=> count_q == 10'h000 ##1 status_q[compact_timer_pkg::STAT_PERIOD]
  ) else $error("Period code one did not clear at 128");

  a_no_period_flag: assert property (
    !is_pwm && clear_select_bit |=> !o_period_match_flag
  ) else $error("Period flag set with compare A clearing");

  a_zero_compare_wrap: assert property (
    !is_pwm && clear_select_bit && compare_a_value_q == 10'h000 && count_step &&
    count_q == 10'h3ff |=> count_q == 10'h000 && !o_compare_a_match_flag
  ) else $error("Zero compare A did not overflow silently");

  a_toggle_on_match: assert property (
    operating_mode_field == compact_timer_pkg::MODE_COMPARE &&
    output_function_field == 2'h3 && a_hit |=> cmp_level_q != $past(cmp_level_q)
  ) else $error("Compare A match did not toggle");

  a_initial_level: assert property (
    enable_rise && !is_pwm |=> ##1 o_timer_output_pin == ($past(output_control_bit, 2) ^
    $past(polarity_bit))
  ) else $error("Pin not at initial level after enable rise");

  a_pwm_force_active: assert property (
    is_pwm && output_function_field == 2'h1
    |=> o_timer_output_pin == ($past(output_control_bit) ^ $past(polarity_bit))
  ) else $error("Forced active level wrong");

  a_timer_not_driven: assert property (
    is_timer |=> !o_timer_output_enable
  ) else $error("Pin driven in timer mode");

  a_high_read_latch: assert property (
    rd_cnt_hi ##1 (i_read && i_address == compact_timer_pkg::OFF_COUNT_LOW)
    |=> o_read_data == $past(count_q[7:0], 2)
  ) else $error("Low count byte not taken from high read");

  a_compare_write_pair: assert property (
    wr_cmp_hi |=> compare_a_value_q == {$past(i_write_data[1:0]), $past(low_buffer_q)}
  ) else $error("Compare A pair not latched together");

  c_compare_toggle: cover property (a_hit && output_function_field == 2'h3 && !is_pwm);
  c_period_match: cover property (p_set && period_code != 3'h0);
  c_pwm_waveform: cover property (is_pwm && output_function_field == 2'h2 && pwm_active);
  c_external_count: cover property (count_step && ext_rise);

endmodule

// ==== tb/compact_10bit_timer_compare_tb.sv ====
// Self-checking bench for the compact 10-bit compare timer.
// Assumes the register offsets and field layout of compact_timer_pkg.
`timescale 1ns/1ps
module compact_10bit_timer_compare_tb;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic [2:0] i_address = 3'h0;
  logic [7:0] i_write_data = 8'h00;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic i_sub_clock = 1'b0;
  logic i_external_count_input = 1'b0;
  logic [7:0] o_read_data;
  logic o_timer_output_pin;
  logic o_timer_output_pin_inverse;
  logic o_timer_output_enable;
  logic o_compare_a_match_flag;
  logic o_period_match_flag;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] d;
  logic [9:0] c1v;
  logic [9:0] c2v;
  // {write, address, data or expected read}
  logic [11:0] regs [0:12] = '{12'h93c, 12'h13c, 12'hc34, 12'hdff, 12'h503, 12'h434,
    12'hbff, 12'h300, 12'h200, 12'hfff, 12'h700, 12'h000, 12'h900};
  // {control_1, pin after enable, pin after compare A match}
  logic [9:0] cmp [0:5] = '{{8'h38, 2'b10}, {8'h28, 2'b11}, {8'h18, 2'b10},
    {8'h08, 2'b11}, {8'h20, 2'b01}, {8'h1c, 2'b01}};
  // {control_1, compare A, window, expected high cycles}
  logic [35:0] pwm [0:5] = '{{8'ha8, 10'h020, 9'd128, 9'd32}, {8'hac, 10'h020, 9'd128, 9'd96},
    {8'ha0, 10'h020, 9'd128, 9'd96}, {8'h88, 10'h020, 9'd128, 9'd0},
    {8'h98, 10'h020, 9'd128, 9'd128}, {8'haa, 10'h100, 9'd256, 9'd128}};
  int per [0:7] = '{512, 128, 2048, 8192, 896, 896, 1152, 1152};

  always #5 i_clock = ~i_clock;
  // Slow sources, with periods of 7 and 9 system clock cycles
  // Toggles land on clock edges: non-blocking keeps the sampling order fixed
  always #35 i_sub_clock <= ~i_sub_clock;
  always #45 i_external_count_input <= ~i_external_count_input;

  compact_timer_module i_compact_timer_module (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_address(i_address),
    .i_write_data(i_write_data),
    .i_write(i_write),
    .i_read(i_read),
    .o_read_data(o_read_data),
    .i_sub_clock(i_sub_clock),
    .i_external_count_input(i_external_count_input),
    .o_timer_output_pin(o_timer_output_pin),
    .o_timer_output_pin_inverse(o_timer_output_pin_inverse),
    .o_timer_output_enable(o_timer_output_enable),
    .o_compare_a_match_flag(o_compare_a_match_flag),
    .o_period_match_flag(o_period_match_flag)
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_address <= a;
    i_write_data <= v;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_address <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 v = o_read_data;
  endtask

  // High byte first, so the low byte comes from the same snapshot
  task automatic rd_cnt(output logic [9:0] c);
    logic [7:0] hi;
    logic [7:0] lo;
    @(posedge i_clock);
    i_read <= 1'b1;
    i_address <= 3'h3;
    @(posedge i_clock);
    i_address <= 3'h2;
    #1 hi = o_read_data;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 lo = o_read_data;
    c = {hi[1:0], lo};
  endtask

  task automatic wait_fl(input bit pf, output int k);
    k = 0;
    do begin
      @(posedge i_clock);
      #1 k++;
    end while (((pf ? o_period_match_flag : o_compare_a_match_flag) !== 1'b1) && k < 20000);
  endtask

  task automatic tally(input int which, input int win, output int k);
    k = 0;
    repeat (win) begin
      @(posedge i_clock);
      #1 if ((which == 0 ? o_timer_output_pin : which == 1 ? o_compare_a_match_flag
          : o_period_match_flag) === 1'b1) k++;
    end
  endtask

  // Module is switched off around every change of mode or output function
  task automatic setup(input logic [7:0] c0, input logic [7:0] c1, input logic [9:0] a);
    wr(3'h0, c0 & 8'hf7);
    wr(3'h4, a[7:0]);
    wr(3'h5, {6'h00, a[9:8]});
    wr(3'h1, c1);
    wr(3'h0, c0);
    repeat (5) @(posedge i_clock);
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clock);
    chk("inverse in reset", 16'h1, {15'h0, o_timer_output_pin_inverse});
    i_arst_n <= 1'b1;
    foreach (regs[i]) begin
      if (regs[i][11]) begin
        wr(regs[i][10:8], regs[i][7:0]);
      end else begin
        rd(regs[i][10:8], d);
        chk("register read", {8'h0, regs[i][7:0]}, {8'h0, d});
      end
    end
    foreach (cmp[i]) begin
      setup(8'h19, cmp[i][9:2], 10'h010);
      chk("pin initial", {15'h0, cmp[i][1]}, {15'h0, o_timer_output_pin});
      chk("pin inverse", {15'h0, ~cmp[i][1]}, {15'h0, o_timer_output_pin_inverse});
      wait_fl(1'b0, n);
      chk("A flag in time", 16'h1, {15'h0, n < 200});
      repeat (3) @(posedge i_clock);
      #1 chk("pin after A", {15'h0, cmp[i][0]}, {15'h0, o_timer_output_pin});
      wait_fl(1'b1, n);
      repeat (3) @(posedge i_clock);
      #1 chk("pin after P", {15'h0, cmp[i][0]}, {15'h0, o_timer_output_pin});
    end
    for (int s = 0; s < 8; s++) begin
      setup({1'b0, s[2:0], 4'h9}, 8'h00, 10'h000);
      wait_fl(1'b1, n);
      wait_fl(1'b1, n);
      chk("period cycles", 16'(per[s]), 16'(n));
    end
    setup(8'h18, 8'h00, 10'h000);
    wait_fl(1'b1, n);
    wait_fl(1'b1, n);
    chk("overflow period", 16'd1024, 16'(n));
    setup(8'h19, 8'h01, 10'h0c8);
    wait_fl(1'b0, n);
    wait_fl(1'b0, n);
    chk("A clear period", 16'd200, 16'(n));
    tally(2, 450, n);
    chk("P flags with A clear", 16'h0, 16'(n));
    setup(8'h19, 8'h01, 10'h000);
    tally(1, 1100, n);
    chk("A flags with zero A", 16'h0, 16'(n));
    setup(8'h18, 8'h00, 10'h000);
    repeat (200) @(posedge i_clock);
    wr(3'h0, 8'h98);
    rd_cnt(c1v);
    repeat (40) @(posedge i_clock);
    rd_cnt(c2v);
    chk("paused count", {6'h0, c1v}, {6'h0, c2v});
    wr(3'h0, 8'h18);
    rd_cnt(c2v);
    chk("resumed count", 16'h1, {15'h0, c2v > c1v && c2v < c1v + 10'h00a});
    wr(3'h0, 8'h10);
    rd_cnt(c1v);
    repeat (40) @(posedge i_clock);
    rd_cnt(c2v);
    chk("count held when off", {6'h0, c1v}, {6'h0, c2v});
    // Both flags were raised earlier and never cleared; counter is off now
    rd(3'h6, d);
    chk("status both flags", 16'h0003, {8'h0, d});
    wr(3'h6, 8'h01);
    rd(3'h6, d);
    chk("status after A clear", 16'h0002, {8'h0, d});
    wr(3'h0, 8'h18);
    rd_cnt(c2v);
    chk("count cleared on", 16'h1, {15'h0, c2v < 10'h00a});
    setup(8'h19, 8'hc0, 10'h000);
    chk("timer mode enable", 16'h0, {15'h0, o_timer_output_enable});
    wait_fl(1'b1, n);
    wait_fl(1'b1, n);
    chk("timer mode period", 16'd128, 16'(n));
    foreach (pwm[i]) begin
      setup(8'h19, pwm[i][35:28], pwm[i][27:18]);
      tally(0, int'(pwm[i][17:9]), n);
      chk("pwm high cycles", 16'(pwm[i][8:0]), 16'(n));
      chk("pin enable", 16'h1, {15'h0, o_timer_output_enable});
    end
    wrap_up();
  end
endmodule
